// file: adcsi_cfg.svh
`ifndef ADCSI_CFG_SVH
`define ADCSI_CFG_SVH
`define ADCSI_NUM_SEQ 4
`define ADCSI_OFF_SEQ_ENABLE 12'h000
`define ADCSI_OFF_RAW_STATUS 12'h004
`define ADCSI_OFF_IRQ_MASK 12'h008
`define ADCSI_OFF_STATUS_CLEAR 12'h00C
`define ADCSI_FIELD_LSB 0
`define ADCSI_FIELD_MSB 3
`define ADCSI_RESET_FIELD 4'h0
`define ADCSI_RESERVED_READ 28'h0000000
`endif

// file: adcsi_pkg.sv
package adcsi_pkg;
    typedef logic [3:0] adcsi_field_type;
    typedef logic [11:0] adcsi_addr_type;
    typedef logic [31:0] adcsi_data_type;
    typedef enum logic [1:0] {
        ADCSI_IDLE = 2'b01,
        ADCSI_ACCESS = 2'b10
    } adcsi_apb_state_type;
endpackage

// file: adcsi_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
module adcsi_flag_bit (
    input wire logic clk_in,   // System clock
    input wire logic rst_in,   // Sync reset, active high
    input wire logic set_in,   // Completion event
    input wire logic clear_in, // Write-one clear
    output logic flag_out      // Sticky flag
);
    logic flag_ff;
    logic nxt_flag;

    // Set beats clear so a completion in the clear cycle survives
    assign nxt_flag = set_in | (flag_ff & ~clear_in); // [RL2] [RL12]

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_out = flag_ff;
endmodule // adcsi_flag_bit
`default_nettype wire

// file: adcsi_top.sv
// Overview of operation
// [RL1] Four enable bits 3:0, reset zero, run or idle each sequencer.
// [RL2] Raw done flag set when an interrupt-marked sample finishes conversion.
// [RL3] Raw flags readable any time regardless of mask, so software can poll.
// [RL4] Four mask bits 3:0, reset zero, forward raw flags to interrupt.
// [RL5] Each mask bit gates only its own sequencer.
// [RL6] Status-and-clear read returns raw flag AND mask per bit.
// [RL7] Writing one to a status-and-clear bit clears that interrupt.
// [RL8] That write-one also clears the raw flag even when masked off.
// [RL9] Bits 31:4 reserved; read here as zero, software preserves them.
// [RL10] Each masked bit is a level interrupt while flag and mask are one.
// [RL11] Each enable bit affects only its own sequencer.
// [RL12] Writing zero does nothing; a same-cycle completion keeps the flag set.
`timescale 1ns/1ps
`default_nettype none
`include "adcsi_cfg.svh"
module adcsi_top (
    input wire logic clk_in,                         // System clock, 200 MHz
    input wire logic rst_in,                         // Sync reset, active high
    input wire logic psel_in,                        // APB select
    input wire logic penable_in,                     // APB enable
    input wire logic pwrite_in,                      // APB write
    input wire adcsi_pkg::adcsi_addr_type paddr_in,  // APB byte address
    input wire adcsi_pkg::adcsi_data_type pwdata_in, // APB write data
    input wire adcsi_pkg::adcsi_field_type sample_done_in, // Per-seq completion pulse
    input wire adcsi_pkg::adcsi_field_type sample_irq_request_bit_in, // Sample irq request
    output adcsi_pkg::adcsi_data_type prdata_out,    // APB read data
    output logic pready_out,                         // APB ready
    output logic pslverr_out,                        // APB error, unmapped
    output adcsi_pkg::adcsi_field_type seq_enable_bit_out, // Per-seq run enable
    output adcsi_pkg::adcsi_field_type seq_irq_out,  // Per-seq level interrupts
    output logic irq_out                             // Combined interrupt
);
    import adcsi_pkg::*;

    adcsi_apb_state_type state_ff;
    adcsi_apb_state_type nxt_state;
    adcsi_field_type enable_ff;
    adcsi_field_type mask_ff;
    adcsi_field_type raw_done_flag;
    adcsi_field_type masked_status;
    adcsi_field_type seq_irq_ff;
    logic irq_ff;
    adcsi_data_type prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    wire logic setup_phase;
    wire logic access_done;
    wire logic hit_enable;
    wire logic hit_raw;
    wire logic hit_mask;
    wire logic hit_clear;
    wire logic hit_any;
    wire logic wr_enable;
    wire logic wr_mask;
    wire logic wr_clear;
    wire adcsi_field_type clear_bits;
    wire adcsi_field_type done_event;
    wire adcsi_field_type read_field;
    wire adcsi_data_type read_word;

    // No wait state: pready is registered at the setup edge, so the first access cycle completes
    assign setup_phase = psel_in & ~penable_in;
    assign access_done = pready_ff & psel_in & penable_in;

    assign hit_enable = (paddr_in == `ADCSI_OFF_SEQ_ENABLE);
    assign hit_raw = (paddr_in == `ADCSI_OFF_RAW_STATUS);
    assign hit_mask = (paddr_in == `ADCSI_OFF_IRQ_MASK);
    assign hit_clear = (paddr_in == `ADCSI_OFF_STATUS_CLEAR);
    assign hit_any = hit_enable | hit_raw | hit_mask | hit_clear;

    // Writes take effect only at the completing access edge
    assign wr_enable = access_done & pwrite_in & hit_enable;
    assign wr_mask = access_done & pwrite_in & hit_mask;
    assign wr_clear = access_done & pwrite_in & hit_clear;
    assign clear_bits = wr_clear ? pwdata_in[`ADCSI_FIELD_MSB:`ADCSI_FIELD_LSB]
                                 : `ADCSI_RESET_FIELD; // [RL7] [RL8] [RL12]

    // Completion only counts while the sequencer runs and the sample asked for it
    assign done_event = sample_done_in & sample_irq_request_bit_in & enable_ff; // [RL2]

    assign masked_status = raw_done_flag & mask_ff; // [RL6] [RL5]

    assign read_field = hit_enable ? enable_ff :
                        hit_raw ? raw_done_flag :      // [RL3]
                        hit_mask ? mask_ff :
                        hit_clear ? masked_status :    // [RL6]
                        `ADCSI_RESET_FIELD;
    // Reserved upper bits read zero; writes to them are dropped
    assign read_word = {`ADCSI_RESERVED_READ, read_field}; // [RL9]

    genvar gi;
    generate
        for (gi = 0; gi < `ADCSI_NUM_SEQ; gi = gi + 1) begin : g_flag
            adcsi_flag_bit u_flag (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .set_in(done_event[gi]),
                .clear_in(clear_bits[gi]), // [RL8]
                .flag_out(raw_done_flag[gi])
            );
        end
    endgenerate

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ADCSI_IDLE: begin
                if (setup_phase) begin
                    nxt_state = ADCSI_ACCESS;
                end
            end
            ADCSI_ACCESS: begin
                nxt_state = ADCSI_IDLE;
            end
            default: begin
                nxt_state = ADCSI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= ADCSI_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            pready_ff <= (state_ff == ADCSI_IDLE) & setup_phase;
            pslverr_ff <= (state_ff == ADCSI_IDLE) & setup_phase & ~hit_any;
            if ((state_ff == ADCSI_IDLE) & setup_phase & ~pwrite_in) begin
                prdata_ff <= read_word;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enable_ff <= `ADCSI_RESET_FIELD; // [RL1]
            mask_ff <= `ADCSI_RESET_FIELD;   // [RL4]
        end else begin
            if (wr_enable) begin
                // Full field write; each bit drives only its own sequencer
                enable_ff <= pwdata_in[`ADCSI_FIELD_MSB:`ADCSI_FIELD_LSB]; // [RL1] [RL11]
            end
            if (wr_mask) begin
                mask_ff <= pwdata_in[`ADCSI_FIELD_MSB:`ADCSI_FIELD_LSB]; // [RL4] [RL5]
            end
        end
    end

    // Level interrupts, one cycle behind the flags so outputs are registered
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            seq_irq_ff <= `ADCSI_RESET_FIELD;
            irq_ff <= 1'b0;
        end else begin
            seq_irq_ff <= masked_status; // [RL10]
            irq_ff <= |masked_status;    // [RL10]
        end
    end

    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign seq_enable_bit_out = enable_ff; // [RL1]
    assign seq_irq_out = seq_irq_ff;
    assign irq_out = irq_ff;
endmodule // adcsi_top
`default_nettype wire

// file: adcsi_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcsi_top_assertions (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire adcsi_pkg::adcsi_addr_type paddr_in,
    input wire adcsi_pkg::adcsi_data_type pwdata_in,
    input wire adcsi_pkg::adcsi_field_type sample_done_in,
    input wire adcsi_pkg::adcsi_field_type sample_irq_request_bit_in,
    input wire adcsi_pkg::adcsi_data_type prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire adcsi_pkg::adcsi_field_type seq_enable_bit_out,
    input wire adcsi_pkg::adcsi_field_type seq_irq_out,
    input wire logic irq_out
);
    import adcsi_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic acc = psel_in && penable_in && pready_out;
    sequence wr_s(a);
        acc && pwrite_in && paddr_in == a;
    endsequence
    a_enable_write: assert property (wr_s(12'h000) |=>
        seq_enable_bit_out == $past(pwdata_in[3:0])) else $error("enable not written");
    a_enable_hold: assert property (!(acc && pwrite_in && paddr_in == 12'h000) |=>
        $stable(seq_enable_bit_out)) else $error("enable moved");
    a_mask_gates: assert property (wr_s(12'h008) ##0 pwdata_in[3:0] == 4'h0 |=>
        ##1 seq_irq_out == 4'h0) else $error("masked irq seen");
    a_clear_drops: assert property (wr_s(12'h00C) ##0 (pwdata_in[3:0] == 4'hF
        && sample_done_in == 4'h0) |=> ##1 seq_irq_out == 4'h0) else $error("not cleared");
    a_irq_level: assert property ((seq_irq_out != 4'h0) |-> ##[0:1] irq_out)
        else $error("irq missing");
    a_reset_zero: assert property ($fell(rst_in) |->
        seq_enable_bit_out == 4'h0 && seq_irq_out == 4'h0) else $error("reset value");
    a_read_reserved: assert property (acc && !pwrite_in |->
        prdata_out[31:4] == 28'h0) else $error("reserved bits set");
    a_error_unmapped: assert property (acc && paddr_in > 12'h00C |-> pslverr_out)
        else $error("no error response");
endmodule // adcsi_top_assertions
`default_nettype wire

// file: adcsi_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcsi_cpu_model (
    input wire logic clk_in,  // System clock
    input wire logic rst_in,  // Sync reset
    input wire logic irq_in,  // Level request
    output logic [3:0] taken_out // Handler entries
);
    logic irq_ff;
    logic [3:0] taken_ff;
    assign taken_out = taken_ff;
    // Level input: only a new rise counts as a fresh entry
    always_ff @(posedge clk_in) begin
        irq_ff <= rst_in ? 1'b0 : irq_in;
        taken_ff <= rst_in ? 4'h0 : taken_ff + 4'(irq_in && !irq_ff);
    end
endmodule // adcsi_cpu_model
`default_nettype wire

// file: adcsi_sequencer_enable_and_interrupt_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_enable_and_interrupt_test;
    import adcsi_pkg::*;
    logic clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, irq_out;
    adcsi_addr_type paddr_in;
    adcsi_data_type pwdata_in, prdata_out, got;
    adcsi_field_type sample_done_in, sample_irq_request_bit_in, seq_enable_bit_out, seq_irq_out;
    logic [3:0] taken;
    logic gerr;
    int n_fail = 0;
    int compares = 0;
    adcsi_top dut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .sample_done_in, .sample_irq_request_bit_in, .prdata_out,
        .pready_out, .pslverr_out, .seq_enable_bit_out, .seq_irq_out, .irq_out);
    adcsi_cpu_model cpu (.clk_in, .rst_in, .irq_in(irq_out), .taken_out(taken));
    task chk(input adcsi_data_type g, input adcsi_data_type e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Event e rides on the access cycle, to land on the same edge as the write
    task apb(input logic w, input adcsi_addr_type a, input adcsi_data_type d,
        input adcsi_field_type e);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        sample_done_in <= e;
        sample_irq_request_bit_in <= e;
        // Ready judged mid-cycle, where it stands settled for the coming rising edge
        while (!done && n < 50) begin
            @(negedge clk_in);
            done = (pready_out === 1'b1);
            got = prdata_out;
            gerr = pslverr_out;
            n++;
            @(posedge clk_in);
            sample_done_in <= 4'h0;
        end
        if (!done) begin
            n_fail++;
        end
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task rd(input adcsi_addr_type a, input adcsi_data_type x);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(got, x);
    endtask
    task ev(input adcsi_field_type d, input adcsi_field_type r);
        @(posedge clk_in);
        sample_done_in <= d;
        sample_irq_request_bit_in <= r;
        @(posedge clk_in);
        sample_done_in <= 4'h0;
    endtask
    task tally_and_finish;
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        #20000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        {rst_in, psel_in, penable_in, pwrite_in} = 4'h8;
        {paddr_in, pwdata_in, sample_done_in, sample_irq_request_bit_in} = '0;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0);
        rd(12'h010, 32'h0);
        chk({31'h0, gerr}, 32'h1);
        apb(1'b1, 12'h000, 32'h5, 4'h0);
        @(negedge clk_in);
        chk({28'h0, seq_enable_bit_out}, 32'h5);
        ev(4'hF, 4'hF);
        rd(12'h004, 32'h5);
        apb(1'b1, 12'h000, 32'hF, 4'h0);
        ev(4'hF, 4'h2);
        rd(12'h004, 32'h7);
        rd(12'h00C, 32'h0);
        @(negedge clk_in);
        chk({31'h0, irq_out}, 32'h0);
        apb(1'b1, 12'h008, 32'h2, 4'h0);
        rd(12'h00C, 32'h2);
        @(negedge clk_in);
        chk({27'h0, irq_out, seq_irq_out}, 32'h12);
        apb(1'b1, 12'h008, 32'h0, 4'h0);
        repeat (2) @(negedge clk_in);
        chk({27'h0, irq_out, seq_irq_out}, 32'h0);
        apb(1'b1, 12'h008, 32'h2, 4'h0);
        apb(1'b1, 12'h004, 32'h0, 4'h0);
        rd(12'h004, 32'h7);
        apb(1'b1, 12'h00C, 32'h4, 4'h0);
        rd(12'h004, 32'h3);
        apb(1'b1, 12'h00C, 32'h0, 4'h0);
        rd(12'h004, 32'h3);
        apb(1'b1, 12'h00C, 32'h2, 4'h2);
        rd(12'h004, 32'h3);
        apb(1'b1, 12'h00C, 32'hF, 4'h0);
        rd(12'h004, 32'h0);
        @(negedge clk_in);
        chk({27'h0, irq_out, taken}, 32'h2);
        // Mid-run reset must drop enables and masks again
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(12'h000, 32'h0);
        rd(12'h008, 32'h0);
        tally_and_finish;
    end
endmodule // adc_sequencer_enable_and_interrupt_test
bind adcsi_top adcsi_top_assertions chk_i (.clk_in, .rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .sample_done_in, .sample_irq_request_bit_in,
    .prdata_out, .pready_out, .pslverr_out, .seq_enable_bit_out, .seq_irq_out, .irq_out);
`default_nettype wire
